// *** hdl/bkrc_pkg.sv ***
/*
  Package for the six-channel buck regulator digital control: register
  offsets, field layouts, reset values, codes and ramp timing.
  Assumes an APB slave with 32-bit data and word-aligned registers.
*/
package bkrc_pkg;

  localparam int unsigned NUM_RAILS = 6;

  // ----------------------------------------------------------------------
  // Register map, one block of words per rail plus globals
  // ----------------------------------------------------------------------
  localparam logic [11:0] OFS_GLOBAL_CTRL = 12'h000;
  localparam logic [11:0] OFS_IRQ_STATUS  = 12'h004;
  localparam logic [11:0] OFS_IRQ_MASK    = 12'h008;
  localparam logic [11:0] OFS_RAIL_BASE   = 12'h040;
  localparam logic [11:0] OFS_RAIL_STRIDE = 12'h010;
  localparam logic [3:0]  OFS_RAIL_VOLT   = 4'h0;
  localparam logic [3:0]  OFS_RAIL_CFG    = 4'h4;
  localparam logic [3:0]  OFS_RAIL_STAT   = 4'h8;

  // Global control fields
  localparam int unsigned GC_OSC_LSB   = 0;
  localparam int unsigned GC_STBY_BIT  = 4;
  localparam int unsigned GC_SYSON_BIT = 5;
  localparam int unsigned GC_TERM_BIT  = 6;

  // Rail config fields
  localparam int unsigned CF_RUNMODE_LSB  = 0;
  localparam int unsigned CF_STBYMODE_LSB = 2;
  localparam int unsigned CF_ILIM_LSB     = 4;
  localparam int unsigned CF_PHASE_LSB    = 6;
  localparam int unsigned CF_RAMP_BIT     = 9;

  // ----------------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------------
  localparam logic [7:0] VCODE_TOP_LOW = 8'h00_B0;   // 1.5 V
  localparam logic [7:0] VCODE_HIGH    = 8'h00_B1;   // 1.8 V
  localparam logic [1:0] MODE_OFF      = 2'h0;
  localparam logic [1:0] MODE_PWM      = 2'h1;
  localparam logic [1:0] MODE_PFM      = 2'h2;
  localparam logic [1:0] MODE_AUTO     = 2'h3;
  localparam logic [2:0] PHASE_ZERO    = 3'h7;
  localparam logic [3:0] OSC_RESET     = 4'h0;

  // Oscillator cycles per 6.25 mV step
  localparam logic [4:0] STEP_SLOW_UP   = 5'd16;
  localparam logic [4:0] STEP_SLOW_DOWN = 5'd24;
  localparam logic [4:0] STEP_FAST_UP   = 5'd8;
  localparam logic [4:0] STEP_FAST_DOWN = 5'd12;
  // Cycles the rail stays off when crossing to or from 1.8 V
  localparam logic [4:0] REENABLE_CYCLES = 5'd16;

  typedef enum logic [1:0] {
    BKRC_IDLE = 2'b00,
    BKRC_RAMP = 2'b01,
    BKRC_OFF  = 2'b11
  } bkrc_state_t;

  typedef struct packed {
    logic [7:0] run_code;
    logic [7:0] stby_code;
    logic [1:0] run_mode;
    logic [1:0] stby_mode;
    logic       ramp_fast;
  } bkrc_rail_cfg_t;

  typedef struct packed {
    logic [7:0] target;
    logic       enable;
    logic [1:0] mode;
  } bkrc_stage_t;

endpackage : bkrc_pkg

// *** hdl/bkrc_rail.sv ***
/*
  One rail's target sequencer: unless tracking, which copies the target
  at once, steps the applied code toward the selected target and forces
  an off gap across the 1.8 V boundary.
  Assumes configuration held stable by the register file.
*/
`timescale 1ns/1ns
`default_nettype none
module bkrc_rail
  import bkrc_pkg::*;
(
  input  wire logic           pclk,
  input  wire logic           presetn,
  input  wire logic [7:0]     target_code,
  input  wire logic           ramp_fast,
  input  wire logic           tracking,
  output logic [7:0]          applied_code,
  output logic                rail_off_forced,
  output logic                busy
);

  bkrc_state_t state;
  bkrc_state_t next_state;
  logic [7:0]  next_applied_code;
  logic [4:0]  tick;
  logic [4:0]  next_tick;
  logic [4:0]  step_len;
  logic        crosses_high;

  assign crosses_high = (target_code == VCODE_HIGH) !=
                        (applied_code == VCODE_HIGH);

  always_comb begin
    if (target_code > applied_code)
      step_len = ramp_fast ? STEP_FAST_UP : STEP_SLOW_UP;
    else
      step_len = ramp_fast ? STEP_FAST_DOWN : STEP_SLOW_DOWN;
  end

  always_comb begin
    next_state        = state;
    next_applied_code = applied_code;
    next_tick         = tick;
    case (state)
      BKRC_IDLE: begin
        next_tick = 5'd0;
        if (tracking)
          next_applied_code = target_code;
        else if (crosses_high)
          next_state = BKRC_OFF;
        else if (target_code != applied_code)
          next_state = BKRC_RAMP;
      end
      BKRC_RAMP: begin
        if (tracking || crosses_high || target_code == applied_code) begin
          next_state = BKRC_IDLE;
        end else if (tick == step_len - 5'd1) begin
          next_tick = 5'd0;
          next_applied_code = (target_code > applied_code) ?
                              applied_code + 8'h01 : applied_code - 8'h01;
        end else begin
          next_tick = tick + 5'd1;
        end
      end
      BKRC_OFF: begin
        if (tick == REENABLE_CYCLES - 5'd1) begin
          next_tick         = 5'd0;
          next_applied_code = target_code;
          next_state        = BKRC_IDLE;
        end else begin
          next_tick = tick + 5'd1;
        end
      end
      default: next_state = BKRC_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state           <= BKRC_IDLE;
      applied_code    <= 8'h00_00;
      tick            <= 5'd0;
      rail_off_forced <= 1'b0;
      busy            <= 1'b0;
    end else begin
      state           <= next_state;
      applied_code    <= next_applied_code;
      tick            <= next_tick;
      rail_off_forced <= (next_state == BKRC_OFF);
      busy            <= (next_state != BKRC_IDLE);
    end
  end

endmodule : bkrc_rail
`default_nettype wire

// *** hdl/bkrc_top.sv ***
/*
  Digital control of six buck regulators behind an APB slave: voltage
  codes, modes, current limit, phase, ramp speed, mode-change interrupt
  and rail six termination tracking. Runs on the selected oscillator as
  pclk. Fuse values are static inputs sampled after reset release.
*/
`timescale 1ns/1ns
`default_nettype none
module bkrc_top
  import bkrc_pkg::*;
#(
  parameter int unsigned RAILS = NUM_RAILS
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [11:0]         paddr,
  input  wire logic [31:0]         pwdata,
  output logic [31:0]              prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic [8*RAILS-1:0]  voltage_code_fuse,
  input  wire logic [RAILS-1:0]    default_ramp_speed_fuse,
  input  wire logic [RAILS-1:0]    sequenced_fuse,
  input  wire logic [2*RAILS-1:0]  inductor_sel_fuse,
  output logic [8*RAILS-1:0]       rail_target_code,
  output logic [RAILS-1:0]         rail_enable,
  output logic [2*RAILS-1:0]       rail_mode,
  output logic [2*RAILS-1:0]       current_limit_sel,
  output logic [3*RAILS-1:0]       phase_shift_sel,
  output logic [2*RAILS-1:0]       inductor_sel,
  output logic [3:0]               osc_freq_sel,
  output logic                     rail6_track_half_fb,
  output logic                     irq_n_pin
);

  // Decode and read mux are sized for six rails
  if (RAILS != NUM_RAILS) begin : g_bad_rails
    $error("bkrc_top serves exactly six rails");
  end

  // ----------------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------------
  bkrc_rail_cfg_t cfg      [RAILS];
  bkrc_rail_cfg_t next_cfg [RAILS];
  logic [1:0] ilim         [RAILS];
  logic [1:0] next_ilim    [RAILS];
  logic [2:0] phase        [RAILS];
  logic [2:0] next_phase   [RAILS];
  logic [1:0] eff_mode     [RAILS];
  logic [1:0] prev_mode    [RAILS];
  logic [7:0] applied      [RAILS];
  logic [RAILS-1:0] forced_off;
  logic [RAILS-1:0] busy;
  logic [RAILS-1:0] mode_evt;

  logic [3:0]       osc_sel,   next_osc_sel;
  logic             standby,   next_standby;
  logic             system_on, next_system_on;
  logic             term_en,   next_term_en;
  logic [RAILS-1:0] irq_stat,  next_irq_stat;
  logic [RAILS-1:0] irq_mask,  next_irq_mask;
  logic             fuse_load, next_fuse_load;
  logic [31:0]      next_prdata;
  logic             next_pslverr;

  logic        wr_en;
  logic        rd_en;
  logic        wr_chk;
  logic        in_rail;
  logic [11:0] rel;
  logic [3:0]  rail_idx;
  logic [3:0]  sub;

  // APB answers in the access cycle: pready is the setup-cycle flag.
  // Read data and error decoded in setup so they stand with pready
  assign wr_en    = psel && penable && pwrite;
  assign rd_en    = psel && !penable && !pwrite;
  assign wr_chk   = psel && !penable && pwrite;
  assign rel      = paddr - OFS_RAIL_BASE;
  assign rail_idx = rel[7:4];
  assign sub      = rel[3:0];
  assign in_rail  = (paddr >= OFS_RAIL_BASE) &&
                    (rail_idx < 4'(RAILS)) && (rel[11:8] == 4'h0);

  // ----------------------------------------------------------------------
  // Per-rail logic
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < RAILS; g++) begin : g_rail
      logic [7:0] sel_code;
      logic       track;

      // Target follows run or standby state
      assign sel_code = standby ? cfg[g].stby_code : cfg[g].run_code;
      assign track = (g == RAILS - 1) && term_en;
      assign eff_mode[g] = standby ? cfg[g].stby_mode : cfg[g].run_mode;
      assign mode_evt[g] = !fuse_load && (eff_mode[g] != prev_mode[g]);

      bkrc_rail #() u_rail (
        .pclk            (pclk),
        .presetn         (presetn),
        .target_code     (sel_code),
        .ramp_fast       (cfg[g].ramp_fast),
        .tracking        (track),
        .applied_code    (applied[g]),
        .rail_off_forced (forced_off[g]),
        .busy            (busy[g])
      );

      always_comb begin
        next_cfg[g]   = cfg[g];
        next_ilim[g]  = ilim[g];
        next_phase[g] = phase[g];
        if (fuse_load) begin
          next_cfg[g].run_code  = voltage_code_fuse[8*g +: 8];
          next_cfg[g].stby_code = voltage_code_fuse[8*g +: 8];
          next_cfg[g].run_mode  = sequenced_fuse[g] ? MODE_AUTO : MODE_OFF;
          next_cfg[g].stby_mode = sequenced_fuse[g] ? MODE_AUTO : MODE_OFF;
          next_cfg[g].ramp_fast = default_ramp_speed_fuse[g];
          next_phase[g] = PHASE_ZERO;
        end else if (wr_en && in_rail && rail_idx == 4'(g)) begin
          if (sub == OFS_RAIL_VOLT) begin
            if (pwdata[7:0] <= VCODE_HIGH)
              next_cfg[g].run_code = pwdata[7:0];
            if (pwdata[15:8] <= VCODE_HIGH)
              next_cfg[g].stby_code = pwdata[15:8];
          end else if (sub == OFS_RAIL_CFG) begin
            next_cfg[g].run_mode  = pwdata[CF_RUNMODE_LSB +: 2];
            next_cfg[g].stby_mode = pwdata[CF_STBYMODE_LSB +: 2];
            next_ilim[g] = pwdata[CF_ILIM_LSB +: 2];
            if (system_on)
              next_phase[g] = pwdata[CF_PHASE_LSB +: 3];
            if (system_on)
              next_cfg[g].ramp_fast = pwdata[CF_RAMP_BIT];
          end
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg[g]       <= '0;
          ilim[g]      <= 2'h0;
          phase[g]     <= PHASE_ZERO;
          prev_mode[g] <= MODE_OFF;
        end else begin
          cfg[g]       <= next_cfg[g];
          ilim[g]      <= next_ilim[g];
          phase[g]     <= next_phase[g];
          // Fuse preload is not a mode change; later, lag one cycle
          prev_mode[g] <= fuse_load ? next_cfg[g].run_mode : eff_mode[g];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          rail_target_code[8*g +: 8]  <= 8'h00_00;
          rail_enable[g]              <= 1'b0;
          rail_mode[2*g +: 2]         <= MODE_OFF;
          current_limit_sel[2*g +: 2] <= 2'h0;
          phase_shift_sel[3*g +: 3]   <= PHASE_ZERO;
          inductor_sel[2*g +: 2]      <= 2'h0;
        end else begin
          rail_target_code[8*g +: 8]  <= applied[g];
          rail_enable[g]              <= (eff_mode[g] != MODE_OFF) &&
                                         !forced_off[g];
          rail_mode[2*g +: 2]         <= eff_mode[g];
          current_limit_sel[2*g +: 2] <= ilim[g];
          phase_shift_sel[3*g +: 3]   <= phase[g];
          inductor_sel[2*g +: 2]      <= inductor_sel_fuse[2*g +: 2];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------------
  // Globals, interrupt and read mux
  // ----------------------------------------------------------------------
  always_comb begin
    next_osc_sel   = osc_sel;
    next_standby   = standby;
    next_system_on = system_on;
    next_term_en   = term_en;
    next_irq_mask  = irq_mask;
    next_fuse_load = 1'b0;
    next_irq_stat  = irq_stat;
    next_prdata    = 32'h0000_0000;
    next_pslverr   = 1'b0;
    if (wr_en && paddr == OFS_GLOBAL_CTRL) begin
      next_osc_sel   = pwdata[GC_OSC_LSB +: 4];
      next_standby   = pwdata[GC_STBY_BIT];
      next_system_on = pwdata[GC_SYSON_BIT];
      next_term_en   = pwdata[GC_TERM_BIT];
    end
    if (wr_en && paddr == OFS_IRQ_MASK)
      next_irq_mask = pwdata[RAILS-1:0];
    // Write-one-to-clear; a new event in the same cycle wins
    if (wr_en && paddr == OFS_IRQ_STATUS)
      next_irq_stat = irq_stat & ~pwdata[RAILS-1:0];
    next_irq_stat = next_irq_stat | mode_evt;
    if (rd_en) begin
      if (paddr == OFS_GLOBAL_CTRL)
        next_prdata = {25'h000_0000, term_en, system_on, standby, osc_sel};
      else if (paddr == OFS_IRQ_STATUS)
        next_prdata = {26'h000_0000, irq_stat};
      else if (paddr == OFS_IRQ_MASK)
        next_prdata = {26'h000_0000, irq_mask};
      else if (in_rail && sub == OFS_RAIL_VOLT)
        next_prdata = {16'h0000, cfg[rail_idx[2:0]].stby_code,
                       cfg[rail_idx[2:0]].run_code};
      else if (in_rail && sub == OFS_RAIL_CFG)
        next_prdata = {22'h00_0000, cfg[rail_idx[2:0]].ramp_fast,
                       phase[rail_idx[2:0]], ilim[rail_idx[2:0]],
                       cfg[rail_idx[2:0]].stby_mode,
                       cfg[rail_idx[2:0]].run_mode};
      else if (in_rail && sub == OFS_RAIL_STAT)
        next_prdata = {20'h0_0000, inductor_sel_fuse[2*rail_idx[2:0] +: 2],
                       forced_off[rail_idx[2:0]], busy[rail_idx[2:0]],
                       applied[rail_idx[2:0]]};
      else
        next_pslverr = 1'b1;
    end else if (wr_chk && !(paddr == OFS_GLOBAL_CTRL ||
                 paddr == OFS_IRQ_STATUS || paddr == OFS_IRQ_MASK ||
                 (in_rail && (sub == OFS_RAIL_VOLT || sub == OFS_RAIL_CFG))))
      next_pslverr = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      osc_sel   <= OSC_RESET;
      standby   <= 1'b0;
      system_on <= 1'b0;
      term_en   <= 1'b0;
      irq_stat  <= '0;
      irq_mask  <= '0;
      fuse_load <= 1'b1;
      prdata    <= 32'h0000_0000;
      pslverr   <= 1'b0;
      pready    <= 1'b0;
      irq_n_pin <= 1'b1;
      osc_freq_sel        <= OSC_RESET;
      rail6_track_half_fb <= 1'b0;
    end else begin
      osc_sel   <= next_osc_sel;
      standby   <= next_standby;
      system_on <= next_system_on;
      term_en   <= next_term_en;
      irq_stat  <= next_irq_stat;
      irq_mask  <= next_irq_mask;
      fuse_load <= next_fuse_load;
      prdata    <= next_prdata;
      pslverr   <= next_pslverr;
      pready    <= psel && !penable;
      irq_n_pin <= !(|(next_irq_stat & ~next_irq_mask));
      osc_freq_sel        <= next_osc_sel;
      // Rail six reference from half feedback
      rail6_track_half_fb <= next_term_en;
    end
  end

endmodule : bkrc_top
`default_nettype wire

// *** tb/bkrc_top_asserts.sv ***
/*
  Checker for the buck control block: bus answer timing, ramp steps,
  the off gap around the top code and interrupt release.
  Assumes it is bound to the top module and sees only its ports.
*/
`timescale 1ns/1ns
`default_nettype none
module bkrc_top_asserts
  import bkrc_pkg::*;
#(
  parameter int unsigned RAILS = NUM_RAILS
)
(
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         prdata,
  input  wire logic                pready,
  input  wire logic                pslverr,
  input  wire logic [8*RAILS-1:0]  rail_target_code,
  input  wire logic [RAILS-1:0]    rail_enable,
  input  wire logic [3*RAILS-1:0]  phase_shift_sel,
  input  wire logic                irq_n_pin
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic [7:0] code0;
  assign code0 = rail_target_code[7:0];

  sequence s_setup;
    psel && !penable ##1 psel && penable;
  endsequence
  // Plain step inside the ramp range
  sequence s_step;
    $changed(code0) && code0 <= VCODE_TOP_LOW
      && $past(code0) <= VCODE_TOP_LOW && $past(rail_enable[0]);
  endsequence
  sequence s_cross;
    $changed(code0) && (code0 == VCODE_HIGH || $past(code0) == VCODE_HIGH);
  endsequence

  property p_answer;
    s_setup |-> pready;
  endproperty
  property p_one_cycle;
    pready |=> !pready;
  endproperty
  property p_err_zero;
    pready && pslverr && !pwrite |-> prdata == 32'h0;
  endproperty
  property p_code_max;
    code0 <= VCODE_HIGH;
  endproperty
  property p_unit;
    s_step |-> code0 == $past(code0) + 8'h01 || code0 == $past(code0) - 8'h01;
  endproperty
  property p_gap;
    s_step |=> $stable(code0) [*7];
  endproperty
  property p_off;
    s_cross |-> !$past(rail_enable[0]) && !$past(rail_enable[0], 8);
  endproperty
  property p_phase_def;
    $rose(presetn) |-> phase_shift_sel == {RAILS{PHASE_ZERO}};
  endproperty
  property p_irq_rel;
    $rose(irq_n_pin) |-> $past(psel && penable && pwrite && pready)
      || $past(psel && penable && pwrite && pready, 2);
  endproperty

  a_answer: assert property (p_answer)
    else $error("no answer in access cycle");
  a_one_cycle: assert property (p_one_cycle)
    else $error("answer held too long");
  a_err_zero: assert property (p_err_zero)
    else $error("refused read returned data");
  a_code_max: assert property (p_code_max)
    else $error("reserved code applied");
  a_unit: assert property (p_unit)
    else $error("ramp jumped more than one code");
  a_gap: assert property (p_gap)
    else $error("ramp step too soon");
  a_off: assert property (p_off)
    else $error("top code change without off gap");
  a_phase_def: assert property (p_phase_def)
    else $error("phase not zero after reset");
  a_irq_rel: assert property (p_irq_rel)
    else $error("interrupt released without write");
endmodule : bkrc_top_asserts

bind bkrc_top bkrc_top_asserts #(.RAILS(RAILS)) bkrc_top_asserts_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .rail_target_code(rail_target_code), .rail_enable(rail_enable),
  .phase_shift_sel(phase_shift_sel), .irq_n_pin(irq_n_pin)
);
`default_nettype wire

// *** tb/bkrc_stage_model.sv ***
/*
  Behavioural power stage of one rail: turns the applied code, enable
  and mode into an output level in microvolts.
  Assumes registered control lines from the block.
*/
`timescale 1ns/1ns
`default_nettype none
module bkrc_stage_model
  import bkrc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic [7:0]  code,
  input  wire logic        enable,
  input  wire logic [1:0]  mode,
  output logic      [21:0] out_uv
);
  logic [21:0] held_uv;
  always_ff @(posedge pclk) begin
    if (code <= VCODE_TOP_LOW)
      held_uv <= 22'h6_1a80 + 22'(code) * 22'h186a;
    else if (code == VCODE_HIGH)
      held_uv <= 22'h1b_7740;
  end
  assign out_uv = (enable && mode != MODE_OFF) ? held_uv : 22'h0;
endmodule : bkrc_stage_model
`default_nettype wire

// *** tb/tb_bkrc_top.sv ***
/*
  Self-checking bench for the buck control block: APB driver with an
  expectation queue, a read monitor, pin checks and a stage model.
  Assumes the checker binds itself from its own file.
*/
`timescale 1ns/1ns
`default_nettype none
module tb_bkrc_top
  import bkrc_pkg::*;
;
  localparam logic RD = 1'b0;
  localparam logic WR = 1'b1;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        track, irq_n;
  logic [11:0] paddr, lfuse, mode, ilim, lsel;
  logic [31:0] pwdata, prdata;
  logic [47:0] vfuse, code;
  logic [5:0]  rfuse, sfuse, ren;
  logic [17:0] phase;
  logic [3:0]  osc;
  logic [21:0] uv0;
  logic [32:0] exp_q[$];
  int          err_count, num_checks, cyc;

  bkrc_top bkrc_top_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .voltage_code_fuse(vfuse),
    .default_ramp_speed_fuse(rfuse), .sequenced_fuse(sfuse),
    .inductor_sel_fuse(lfuse), .rail_target_code(code),
    .rail_enable(ren), .rail_mode(mode), .current_limit_sel(ilim),
    .phase_shift_sel(phase), .inductor_sel(lsel), .osc_freq_sel(osc),
    .rail6_track_half_fb(track), .irq_n_pin(irq_n));
  bkrc_stage_model bkrc_stage_model_i (.pclk(pclk), .code(code[7:0]),
    .enable(ren[0]), .mode(mode[1:0]), .out_uv(uv0));

  task automatic end_of_test();
    $display("checks %0d errors %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [32:0] got, input logic [32:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d, input logic [32:0] e);
    int n;
    n = 0;
    @(posedge pclk);
    exp_q.push_back(e);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      n++;
      @(posedge pclk);
    end
    if (pready !== 1'b1)
      err_count++;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wait_code(input int r, input logic [7:0] v);
    int n;
    n = 0;
    while (code[8*r +: 8] !== v && n < 4000) begin
      n++;
      @(posedge pclk);
    end
  endtask : wait_code

  function automatic logic [11:0] ra(input int r, input logic [3:0] o);
    return OFS_RAIL_BASE + OFS_RAIL_STRIDE * 12'(r) + {8'h0, o};
  endfunction : ra

  always @(posedge pclk) begin
    if (psel && penable && pready === 1'b1)
      chk({pslverr, pwrite ? 32'h0 : prdata}, exp_q.pop_front());
  end

  // Hang guard, far above the longest ramp
  always @(posedge pclk) begin
    cyc++;
    if (cyc > 20000) begin
      err_count++;
      end_of_test();
    end
  end

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  initial begin
    logic [47:0] v;
    logic [1:0]  m;
    logic [3:0]  oscs[9];
    oscs = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h9, 4'ha, 4'hb, 4'hc};
    void'($urandom(32'he658_739d));
    {presetn, psel, penable, pwrite, paddr, pwdata} <= '0;
    for (int i = 0; i < 6; i++)
      v[8*i +: 8] = 8'($urandom % 176);
    vfuse <= v;
    rfuse <= 6'($urandom);
    sfuse <= 6'($urandom);
    lfuse <= 12'($urandom);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    chk({15'h0, phase}, {15'h0, {6{PHASE_ZERO}}});
    chk({21'h0, lsel}, {21'h0, lfuse});
    for (int r = 0; r < 6; r++) begin
      m = sfuse[r] ? MODE_AUTO : MODE_OFF;
      apb(RD, ra(r, OFS_RAIL_VOLT), 0, {17'h0, {2{vfuse[8*r +: 8]}}});
      apb(RD, ra(r, OFS_RAIL_CFG), 0,
          {23'h0, rfuse[r], PHASE_ZERO, 2'h0, m, m});
    end
    apb(RD, 12'h00c, 0, {1'b1, 32'h0});
    apb(WR, 12'h00c, 0, {1'b1, 32'h0});
    // Not yet system-on: ramp bit and phase writes are ignored
    apb(WR, ra(2, OFS_RAIL_CFG), {22'h0, ~rfuse[2], 9'h005}, 0);
    apb(RD, ra(2, OFS_RAIL_CFG), 0, {23'h0, rfuse[2], 9'h1c5});
    foreach (oscs[i]) begin
      apb(WR, OFS_GLOBAL_CTRL, {28'h2, oscs[i]}, 0);
      repeat (2) @(posedge pclk);
      chk({29'h0, osc}, {29'h0, oscs[i]});
    end
    apb(RD, OFS_GLOBAL_CTRL, 0, {29'h2, 4'hc});
    for (int i = 0; i < 4; i++) begin
      apb(WR, ra(1, OFS_RAIL_CFG), {23'h0, PHASE_ZERO, {3{2'(i)}}}, 0);
      repeat (2) @(posedge pclk);
      chk({31'h0, mode[3:2]}, {31'h0, 2'(i)});
      chk({31'h0, ilim[3:2]}, {31'h0, 2'(i)});
    end
    for (int i = 0; i < 8; i++) begin
      apb(WR, ra(2, OFS_RAIL_CFG), {22'h0, 1'b1, 3'(i), 6'h5}, 0);
      repeat (2) @(posedge pclk);
      chk({30'h0, phase[8:6]}, {30'h0, 3'(i)});
    end
    // Power up in PWM to dodge false limits
    apb(WR, ra(0, OFS_RAIL_CFG), 32'h3c9, 0);
    apb(WR, ra(0, OFS_RAIL_VOLT), {16'h0, vfuse[7:0], 8'h10}, 0);
    wait_code(0, 8'h10);
    chk({25'h0, code[7:0]}, 33'h10);
    repeat (2) @(posedge pclk);
    chk({11'h0, uv0}, {11'h0, 22'h7_a120});
    apb(WR, ra(0, OFS_RAIL_VOLT), {16'h0, vfuse[7:0], VCODE_HIGH}, 0);
    wait_code(0, VCODE_HIGH);
    chk({25'h0, code[7:0]}, {25'h0, VCODE_HIGH});
    repeat (2) @(posedge pclk);
    chk({11'h0, uv0}, {11'h0, 22'h1b_7740});
    apb(WR, ra(0, OFS_RAIL_VOLT), {16'h0, vfuse[7:0], 8'hff}, 0);
    apb(RD, ra(0, OFS_RAIL_VOLT), 0, {17'h0, vfuse[7:0], VCODE_HIGH});
    apb(WR, ra(0, OFS_RAIL_VOLT), {16'h0, vfuse[7:0], 8'h05}, 0);
    wait_code(0, 8'h05);
    chk({25'h0, code[7:0]}, 33'h05);
    apb(WR, OFS_IRQ_MASK, 32'h3e, 0);
    apb(WR, OFS_IRQ_STATUS, 32'h3f, 0);
    repeat (2) @(posedge pclk);
    chk({32'h0, irq_n}, 33'h1);
    apb(WR, OFS_GLOBAL_CTRL, 32'h3c, 0);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq_n}, 33'h0);
    apb(RD, OFS_IRQ_STATUS, 0, 33'h1);
    wait_code(0, vfuse[7:0]);
    chk({25'h0, code[7:0]}, {25'h0, vfuse[7:0]});
    apb(WR, OFS_IRQ_STATUS, 32'h1, 0);
    apb(WR, OFS_IRQ_MASK, 32'h3f, 0);
    apb(WR, OFS_GLOBAL_CTRL, 32'h2c, 0);
    repeat (3) @(posedge pclk);
    chk({32'h0, irq_n}, 33'h1);
    apb(RD, OFS_IRQ_STATUS, 0, 33'h1);
    // Rail five kept at 800 mV or more
    apb(WR, ra(4, OFS_RAIL_VOLT), 32'h4040, 0);
    apb(WR, OFS_GLOBAL_CTRL, 32'h6c, 0);
    repeat (2) @(posedge pclk);
    chk({32'h0, track}, 33'h1);
    apb(WR, ra(5, OFS_RAIL_VOLT), 32'h5050, 0);
    repeat (3) @(posedge pclk);
    chk({25'h0, code[47:40]}, 33'h50);
    end_of_test();
  end
endmodule : tb_bkrc_top
`default_nettype wire
